// File: bench/spc_host_model.sv
// Host reply sink with random stalls and a scaler read responder.
`default_nettype none
module spc_host_model (
  input wire logic core_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic got,
  output logic [7:0] got_byte,
  input wire logic scaler_rd_en,
  input wire logic [10:0] scaler_rd_addr,
  output logic scaler_rd_valid,
  output logic [7:0] scaler_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] pend[$];
  // Scaler content in which every address field changes the byte.
  function automatic logic [7:0] sd(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h15};
  endfunction
  initial begin
    tx_ready = 1'b0;
    got = 1'b0;
    got_byte = 8'h00;
    scaler_rd_valid = 1'b0;
    scaler_rd_data = 8'h00;
  end
  // The sink stalls at random, as a slow host would.
  always @(posedge core_clk) begin
    got <= tx_valid & tx_ready;
    got_byte <= tx_byte;
    tx_ready <= ($urandom % 4) != 0;
  end
  // Reads are answered late or at once; idle data keeps toggling so stale
  // bytes are never mistaken for answers.
  always @(posedge core_clk) begin
    if (scaler_rd_en === 1'b1) begin
      pend.push_back(scaler_rd_addr);
    end
    if ((pend.size() > 0) && (($urandom % 2) == 1)) begin
      scaler_rd_valid <= 1'b1;
      scaler_rd_data <= sd(pend.pop_front());
    end else begin
      scaler_rd_valid <= 1'b0;
      scaler_rd_data <= ~scaler_rd_data;
    end
  end
endmodule
`default_nettype wire

// File: bench/spc_serial_cmd_tb_top.sv
// Self-checking bench for the serial power and config command block.
`default_nettype none
module spc_serial_cmd_tb_top
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] spc_bq_t[$];
  logic core_clk, sys_rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, rx_byte, tx_byte, got_byte, power_state, scaler_rd_data;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic rx_valid, rx_ready, tx_valid, tx_ready, got, power_strobe, op_mode;
  logic nv_mode_in, nv_mode_wr, factory_recall, scaler_present;
  logic scaler_rd_en, scaler_rd_valid, scaler_wr_en;
  logic [7:0] scaler_wr_data, b, p;
  logic [10:0] scaler_rd_addr, scaler_wr_addr;
  logic [7:0] exp_q[$];
  logic [18:0] st_q[$];
  spc_bq_t none, d, r;
  int fails, checks_done, n_pwr, n_nv, n_rec, n_nak;
  spc_serial_cmd dut (.core_clk, .sys_rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid, .rx_byte, .rx_ready, .tx_valid,
    .tx_byte, .tx_ready, .power_state, .power_strobe, .op_mode, .nv_mode_in, .nv_mode_wr,
    .factory_recall, .scaler_present, .scaler_rd_en, .scaler_rd_addr, .scaler_rd_valid,
    .scaler_rd_data, .scaler_wr_en, .scaler_wr_addr, .scaler_wr_data);
  spc_host_model u_host (.core_clk, .tx_valid, .tx_byte, .tx_ready, .got, .got_byte,
    .scaler_rd_en, .scaler_rd_addr, .scaler_rd_valid, .scaler_rd_data);
  always #20 core_clk = ~core_clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up(string n);
    chk(n, 32'h1, 32'h0);
    end_of_test();
  endtask
  // Builds a frame with its header checksum, plus the data checksum when dk is set.
  function automatic spc_bq_t pack(logic [7:0] a, logic [23:0] c, spc_bq_t dd, bit dk);
    spc_bq_t q;
    logic [7:0] s;
    q = '{a, SYNC_BYTE, c[23:16], c[15:8], c[7:0], 8'(dd.size())};
    s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(~s);
    s = 8'h00;
    foreach (dd[i]) s += dd[i];
    q = {q, dd};
    if (dk) q.push_back(~s);
    return q;
  endfunction
  // ************************************
  // Pulse counters and reply watcher
  // ************************************
  always @(posedge core_clk) begin
    if (power_strobe === 1'b1) n_pwr++;
    if (nv_mode_wr === 1'b1) n_nv++;
    if (factory_recall === 1'b1) n_rec++;
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk("extra reply byte", 32'h0, 32'h1);
      else chk("reply byte", 32'(exp_q.pop_front()), 32'(got_byte));
    end
    if (scaler_wr_en === 1'b1) begin
      if (st_q.size() == 0) chk("extra store", 32'h0, 32'h1);
      else chk("store", 32'(st_q.pop_front()), 32'({scaler_wr_addr, scaler_wr_data}));
    end
  end
  // Sends one request and notes its reply; bad > 0 corrupts that byte.
  task automatic req(logic [23:0] c, spc_bq_t dd, bit ok, spc_bq_t rr, int bad);
    spc_bq_t q;
    int t;
    q = pack(ATT_REQ, c, dd, dd.size() > 0);
    if (bad > 0) q[bad] = ~q[bad];
    if (ok) rr = pack(ATT_ACK, c, rr, 1'b1);
    else rr = pack(ATT_NAK, c, none, 1'b1);
    if (!ok) n_nak++;
    foreach (rr[i]) exp_q.push_back(rr[i]);
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_byte <= q[i];
      t = 0;
      do begin
        @(posedge core_clk);
        t++;
      end while (rx_ready !== 1'b1 && t < 300);
      if (t >= 300) give_up("frame byte taken");
    end
    rx_valid <= 1'b0;
    if (c != CMD_CFG_READ && c != CMD_CFG_STORE) begin
      repeat (2) @(posedge core_clk);
      #1 chk("prompt reply", 32'h1, 32'(tx_valid));
    end
    t = 0;
    while (exp_q.size() > 0 && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 3000) give_up("reply done");
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] dw);
    int t;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dw;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    @(posedge core_clk);
    if (t >= 20) give_up("bus ack");
  endtask
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, rx_valid} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    rx_byte = 8'h00;
    nv_mode_in = 1'b1;
    scaler_present = 1'b1;
    {fails, checks_done, n_pwr, n_nv, n_rec, n_nak} = '0;
    void'($urandom(48));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("mode after reset", 32'h1, 32'(op_mode));
    chk("power after reset", 32'hff, 32'(power_state));
    // The first request names the state already held after reset.
    d = '{PWR_ON, PWR_OFF, PWR_ON, PWR_SLEEP};
    foreach (d[i]) begin
      req(CMD_POWER, '{d[i]}, 1'b1, '{d[i]}, 0);
      chk("power state", 32'(d[i]), 32'(power_state));
    end
    req(CMD_POWER, none, 1'b1, '{PWR_SLEEP}, 0);
    b = 8'($urandom_range(1, 14));
    req(CMD_POWER, '{b}, 1'b0, none, 0);
    req(CMD_POWER, '{PWR_ON, PWR_ON}, 1'b0, none, 0);
    req(CMD_POWER, none, 1'b0, none, 6);
    req(CMD_POWER, '{PWR_OFF}, 1'b0, none, 8);
    chk("power kept", 32'(PWR_SLEEP), 32'(power_state));
    chk("power pulses", 32'h4, 32'(n_pwr));
    $display("test power done");
    for (int m = 0; m < 2; m++) begin
      req(CMD_OP_MODE, '{8'(m)}, 1'b1, '{8'(m)}, 0);
      chk("op mode", 32'(m), 32'(op_mode));
    end
    req(CMD_OP_MODE, none, 1'b1, '{MODE_LEGACY}, 0);
    req(CMD_OP_MODE, '{8'h02}, 1'b0, none, 0);
    chk("mode writes", 32'h2, 32'(n_nv));
    req(CMD_RECALL, '{RECALL_KEY}, 1'b1, '{RECALL_KEY}, 0);
    req(CMD_RECALL, '{8'h00}, 1'b0, none, 0);
    chk("recall pulses", 32'h1, 32'(n_rec));
    $display("test mode and recall done");
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 8'h07 : 8'($urandom_range(0, 6));
      p = (k == 0) ? 8'h03 : 8'($urandom_range(0, 3));
      r = '{b, p};
      for (int j = 0; j < 64; j++) r.push_back(u_host.sd({b[2:0], p[1:0], 6'(j)}));
      req(CMD_CFG_READ, '{b, p}, 1'b1, r, 0);
      d = '{b, p};
      for (int j = 0; j < 64; j++) begin
        d.push_back(8'($urandom));
        st_q.push_back({b[2:0], p[1:0], 6'(j), d[j + 2]});
      end
      req(CMD_CFG_STORE, d, 1'b1, '{b, p}, 0);
      chk("store left", 32'h0, 32'(st_q.size()));
    end
    chk("power untouched", 32'(PWR_SLEEP), 32'(power_state));
    chk("mode untouched", 32'h1, 32'(op_mode));
    req(CMD_CFG_READ, '{8'h08, 8'h00}, 1'b0, none, 0);
    req(CMD_CFG_READ, '{8'h00, 8'h04}, 1'b0, none, 0);
    d[1] = 8'h04;
    req(CMD_CFG_STORE, d, 1'b0, none, 0);
    d[1] = 8'h00;
    void'(d.pop_back());
    req(CMD_CFG_STORE, d, 1'b0, none, 0);
    scaler_present <= 1'b0;
    req(CMD_CFG_READ, '{8'h00, 8'h00}, 1'b0, none, 0);
    scaler_present <= 1'b1;
    req(24'h414243, none, 1'b0, none, 0);
    $display("test config done");
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("status", {22'h0, 1'b0, 1'b1, PWR_SLEEP}, rd);
    wb(1'b1, ADR_NAKCNT, 32'h0);
    wb(1'b0, ADR_NAKCNT, 32'h0);
    chk("nak count", 32'(n_nak), rd);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, ADR_CTRL, 32'h0);
    @(posedge core_clk);
    @(posedge core_clk);
    chk("rx closed", 32'h0, 32'(rx_ready));
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    $display("test registers done");
    nv_mode_in <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("power not kept", 32'hff, 32'(power_state));
    chk("mode restored", 32'h0, 32'(op_mode));
    req(CMD_POWER, none, 1'b1, '{PWR_ON}, 0);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire

// File: hw/spc_pkg.sv
// Constants, types and helpers shared by the serial power and config command block.
`default_nettype none
package spc_pkg;
  // ********************************
  // Frame layout
  // ********************************
  localparam logic [7:0] ATT_REQ = 8'h07;
  localparam logic [7:0] ATT_ACK = 8'h06;
  localparam logic [7:0] ATT_NAK = 8'h15;
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [8:0] POS_ATT = 9'h000;
  localparam logic [8:0] POS_SYNC = 9'h001;
  localparam logic [8:0] POS_LEN = 9'h005;
  localparam logic [8:0] POS_HCHK = 9'h006;
  localparam logic [8:0] POS_DATA = 9'h007;
  localparam logic [8:0] BUF_DEPTH = 9'h042;
  // ********************************
  // Command codes and values
  // ********************************
  localparam logic [23:0] CMD_POWER = 24'h505752;
  localparam logic [23:0] CMD_CFG_READ = 24'h565552;
  localparam logic [23:0] CMD_CFG_STORE = 24'h565553;
  localparam logic [23:0] CMD_OP_MODE = 24'h4d4f44;
  localparam logic [23:0] CMD_RECALL = 24'h524346;
  localparam logic [7:0] PWR_OFF = 8'h00;
  localparam logic [7:0] PWR_SLEEP = 8'h0f;
  localparam logic [7:0] PWR_ON = 8'hff;
  localparam logic [7:0] RECALL_KEY = 8'hff;
  localparam logic [7:0] MODE_CUR_GEN = 8'h00;
  localparam logic [7:0] MODE_LEGACY = 8'h01;
  localparam logic OP_MODE_DEFAULT = 1'b0;
  localparam logic [7:0] LEN_QUERY = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_CFG_READ = 8'h02;
  localparam logic [7:0] LEN_CFG_STORE = 8'h42;
  localparam logic [7:0] BANK_MAX = 8'h07;
  localparam logic [7:0] PKT_MAX = 8'h03;
  localparam logic [5:0] CFG_LAST = 6'h3f;
  localparam logic [6:0] CFG_OFS = 7'h02;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_NAKCNT = 8'h08;
  localparam logic CTRL_EN_RST = 1'b1;
  typedef enum {SPC_RX, SPC_EXEC, SPC_FETCH, SPC_STORE, SPC_TX} spc_state_e;
  typedef enum {ACT_QUERY, ACT_POWER, ACT_MODE, ACT_RECALL, ACT_FETCH, ACT_STORE} spc_act_e;
  // Frame checksums are the complement of the low byte of a sum.
  function automatic logic [7:0] spc_chk(input logic [7:0] s);
    return ~s;
  endfunction
endpackage
`default_nettype wire

// File: hw/spc_serial_cmd.sv
// Command interpreter for power, operation mode, recall and scaler config frames.
// Contract
// - Power frame: attention, sync, code, length one, header check, power byte, data check.
// - Power byte 0x00 is off, 0x0F standby, 0xFF on.
// - Power acknowledge starts as soon as the transition starts, not when done.
// - Requesting the present power state is still acknowledged.
// - Requested power state is not kept across any reset.
// - Each 256-byte config bank moves as four 64-byte packets, both directions.
// - Config read carries bank then packet index; bank valid 0 to 7.
// - Packet index in config read and store is valid 0 to 3.
// - Config store has length 0x42: bank, index, 64 bytes, then data check.
// - Config store goes only to the scaler, never into local settings.
// - Operation mode steers how the menu command set is handled.
// - Operation mode has one data byte: 0x00 current, 0x01 legacy.
// - Operation mode is nonvolatile, restored after reset, default 0x00.
// - Recall with data 0xFF replaces user config with factory copy, then acknowledges; the acknowledge starts in the cycle of the factory_recall pulse.
// - Valid request answered with frame starting 0x06 instead of 0x07.
// - Request that cannot be served gets a negative acknowledge.
`default_nettype none
module spc_serial_cmd
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic [7:0] power_state,
  output logic power_strobe,
  output logic op_mode,
  input wire logic nv_mode_in,
  output logic nv_mode_wr,
  output logic factory_recall,
  input wire logic scaler_present,
  output logic scaler_rd_en,
  output logic [10:0] scaler_rd_addr,
  input wire logic scaler_rd_valid,
  input wire logic [7:0] scaler_rd_data,
  output logic scaler_wr_en,
  output logic [10:0] scaler_wr_addr,
  output logic [7:0] scaler_wr_data
);
  // ********************************
  // State
  // ********************************
  spc_state_e st;
  spc_act_e act;
  logic [7:0] pbuf [0:65];
  logic [8:0] ridx;
  logic [8:0] dj;
  logic [7:0] rsum;
  logic [23:0] cmd;
  logic [7:0] len;
  logic hdr_ok;
  logic dat_ok;
  logic nv_pend;
  logic ctrl_en;
  logic [7:0] nak_cnt;
  logic [7:0] rep_att;
  logic [7:0] rep_len;
  logic [7:0] rep_hck;
  logic [8:0] tidx;
  logic [7:0] dsum;
  logic [5:0] fi;
  logic pend;
  logic take;
  logic good;
  logic [7:0] rl;
  logic [7:0] qval;
  logic [7:0] next_att;
  logic [7:0] next_byte;
  logic [7:0] next_dsum;
  logic [8:0] k;
  logic [8:0] dk;
  logic bank_ok;
  logic pwr_ok;

  assign take = rx_valid && rx_ready && (st == SPC_RX);
  assign dj = ridx - POS_DATA;
  assign bank_ok = (pbuf[0] <= BANK_MAX) && (pbuf[1] <= PKT_MAX) && scaler_present;
  assign pwr_ok = (pbuf[0] == PWR_OFF) || (pbuf[0] == PWR_SLEEP) || (pbuf[0] == PWR_ON);

  // ********************************
  // Request decode
  // ********************************
  always_comb begin
    good = 1'b0;
    act = ACT_QUERY;
    rl = LEN_QUERY;
    qval = 8'h00;
    case (cmd)
      CMD_POWER: begin
        qval = power_state;
        if (len == LEN_QUERY) begin
          good = 1'b1;
          rl = LEN_ONE;
        end else if (len == LEN_ONE && pwr_ok) begin
          good = 1'b1;
          act = ACT_POWER;
          rl = LEN_ONE;
        end
      end
      CMD_OP_MODE: begin
        qval = {7'h00, op_mode};
        if (len == LEN_QUERY) begin
          good = 1'b1;
          rl = LEN_ONE;
        end else if (len == LEN_ONE && (pbuf[0] == MODE_CUR_GEN || pbuf[0] == MODE_LEGACY)) begin
          good = 1'b1;
          act = ACT_MODE;
          rl = LEN_ONE;
        end
      end
      CMD_RECALL: begin
        if (len == LEN_ONE && pbuf[0] == RECALL_KEY) begin
          good = 1'b1;
          act = ACT_RECALL;
          rl = LEN_ONE;
        end
      end
      CMD_CFG_READ: begin
        if (len == LEN_CFG_READ && bank_ok) begin
          good = 1'b1;
          act = ACT_FETCH;
          rl = LEN_CFG_STORE;
        end
      end
      CMD_CFG_STORE: begin
        if (len == LEN_CFG_STORE && bank_ok) begin
          good = 1'b1;
          act = ACT_STORE;
          rl = LEN_CFG_READ;
        end
      end
      default: good = 1'b0;
    endcase
    if (!(hdr_ok && dat_ok)) begin
      good = 1'b0;
    end
    if (!good) begin
      rl = LEN_QUERY;
    end
    next_att = good ? ATT_ACK : ATT_NAK;
  end

  // ********************************
  // Reply byte sequencing
  // ********************************
  always_comb begin
    k = tidx + 9'h001;
    dk = k - POS_DATA;
    next_dsum = dsum;
    if (tidx >= POS_DATA && tidx < POS_DATA + {1'b0, rep_len}) begin
      next_dsum = dsum + tx_byte;
    end
    if (k == POS_SYNC) begin
      next_byte = SYNC_BYTE;
    end else if (k < POS_LEN) begin
      next_byte = (k == POS_SYNC + 9'h001) ? cmd[23:16] : (k == POS_LEN - 9'h001) ? cmd[7:0]
                : cmd[15:8];
    end else if (k == POS_LEN) begin
      next_byte = rep_len;
    end else if (k == POS_HCHK) begin
      next_byte = rep_hck;
    end else if (k < POS_DATA + {1'b0, rep_len}) begin
      next_byte = pbuf[dk[6:0]];
    end else begin
      next_byte = spc_chk(next_dsum);
    end
  end

  // ********************************
  // Frame engine
  // ********************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= SPC_RX;
      ridx <= POS_ATT;
      rsum <= 8'h00;
      cmd <= 24'h000000;
      len <= LEN_QUERY;
      hdr_ok <= 1'b0;
      dat_ok <= 1'b0;
      rx_ready <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tidx <= POS_ATT;
      dsum <= 8'h00;
      rep_att <= ATT_NAK;
      rep_len <= LEN_QUERY;
      rep_hck <= 8'h00;
      power_state <= PWR_ON;
      power_strobe <= 1'b0;
      op_mode <= OP_MODE_DEFAULT;
      nv_pend <= 1'b1;
      nv_mode_wr <= 1'b0;
      factory_recall <= 1'b0;
      scaler_rd_en <= 1'b0;
      scaler_rd_addr <= 11'h000;
      scaler_wr_en <= 1'b0;
      scaler_wr_addr <= 11'h000;
      scaler_wr_data <= 8'h00;
      fi <= 6'h00;
      pend <= 1'b0;
      nak_cnt <= 8'h00;
    end else if (ce) begin
      power_strobe <= 1'b0;
      nv_mode_wr <= 1'b0;
      factory_recall <= 1'b0;
      scaler_rd_en <= 1'b0;
      scaler_wr_en <= 1'b0;
      rx_ready <= ctrl_en && (st == SPC_RX);
      // The stored mode is caught once, after release, since reset may not sample a port.
      if (nv_pend) begin
        op_mode <= nv_mode_in;
        nv_pend <= 1'b0;
      end
      case (st)
        SPC_RX: begin
          if (take) begin
            ridx <= ridx + 9'h001;
            rsum <= rsum + rx_byte;
            if ((ridx == POS_ATT && rx_byte != ATT_REQ) || (ridx == POS_SYNC && rx_byte != SYNC_BYTE)) begin
              ridx <= POS_ATT;
              rsum <= 8'h00;
            end else if (ridx < POS_LEN && ridx > POS_SYNC) begin
              cmd <= {cmd[15:0], rx_byte};
            end else if (ridx == POS_LEN) begin
              len <= rx_byte;
            end else if (ridx == POS_HCHK) begin
              hdr_ok <= (rx_byte == spc_chk(rsum));
              dat_ok <= 1'b1;
              rsum <= 8'h00;
              if (len == LEN_QUERY) begin
                st <= SPC_EXEC;
                rx_ready <= 1'b0;
              end
            end else if (ridx == POS_DATA + {1'b0, len}) begin
              dat_ok <= (rx_byte == spc_chk(rsum));
              st <= SPC_EXEC;
              rx_ready <= 1'b0;
            end else if (dj < BUF_DEPTH) begin
              pbuf[dj[6:0]] <= rx_byte;
            end
          end
        end
        SPC_EXEC: begin
          rep_att <= next_att;
          rep_len <= rl;
          rep_hck <= spc_chk(next_att + SYNC_BYTE + cmd[23:16] + cmd[15:8] + cmd[7:0] + rl);
          tidx <= POS_ATT;
          dsum <= 8'h00;
          fi <= 6'h00;
          pend <= 1'b0;
          st <= SPC_TX;
          tx_valid <= 1'b1;
          tx_byte <= next_att;
          if (!good) begin
            nak_cnt <= nak_cnt + 8'h01;
          end else begin
            case (act)
              ACT_POWER: begin
                power_state <= pbuf[0];
                power_strobe <= 1'b1;
              end
              ACT_MODE: begin
                op_mode <= pbuf[0][0];
                nv_mode_wr <= 1'b1;
              end
              ACT_RECALL: factory_recall <= 1'b1;
              ACT_FETCH, ACT_STORE: begin
                st <= (act == ACT_FETCH) ? SPC_FETCH : SPC_STORE;
                tx_valid <= 1'b0;
              end
              default: pbuf[0] <= qval;
            endcase
          end
        end
        SPC_FETCH: begin
          if (!pend) begin
            scaler_rd_en <= 1'b1;
            scaler_rd_addr <= {pbuf[0][2:0], pbuf[1][1:0], fi};
            pend <= 1'b1;
          end else if (scaler_rd_valid) begin
            pbuf[CFG_OFS + {1'b0, fi}] <= scaler_rd_data;
            pend <= 1'b0;
            fi <= fi + 6'h01;
            if (fi == CFG_LAST) begin
              st <= SPC_TX;
              tx_valid <= 1'b1;
              tx_byte <= rep_att;
            end
          end
        end
        SPC_STORE: begin
          // Stored packets only pass through to the scaler port; no local copy changes.
          scaler_wr_en <= 1'b1;
          scaler_wr_addr <= {pbuf[0][2:0], pbuf[1][1:0], fi};
          scaler_wr_data <= pbuf[CFG_OFS + {1'b0, fi}];
          fi <= fi + 6'h01;
          if (fi == CFG_LAST) begin
            st <= SPC_TX;
            tx_valid <= 1'b1;
            tx_byte <= rep_att;
          end
        end
        SPC_TX: begin
          if (tx_ready) begin
            if (tidx == POS_DATA + {1'b0, rep_len}) begin
              tx_valid <= 1'b0;
              st <= SPC_RX;
              ridx <= POS_ATT;
              rsum <= 8'h00;
            end else begin
              tidx <= k;
              tx_byte <= next_byte;
              dsum <= next_dsum;
            end
          end
        end
        default: st <= SPC_RX;
      endcase
    end
  end

  // ********************************
  // Wishbone register slave
  // ********************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_en <= CTRL_EN_RST;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          ADR_CTRL: wb_dat_o <= {31'h0, ctrl_en};
          ADR_STATUS: wb_dat_o <= {22'h0, st != SPC_RX, op_mode, power_state};
          ADR_NAKCNT: wb_dat_o <= {24'h000000, nak_cnt};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
        ctrl_en <= wb_dat_i[0];
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  a_power_decode: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    power_strobe |-> (power_state == PWR_OFF || power_state == PWR_SLEEP || power_state == PWR_ON))
    else $error("power state outside the three legal codes");
  a_power_prompt: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    power_strobe |-> (tx_valid && tx_byte == ATT_ACK && tidx == POS_ATT))
    else $error("power acknowledge did not start with the transition");
  a_power_same: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    (st == SPC_EXEC && cmd == CMD_POWER && len == LEN_ONE && hdr_ok && dat_ok
     && pbuf[0] == power_state && pwr_ok) |=> (tx_byte == ATT_ACK))
    else $error("repeat of present power state not acknowledged");
  a_power_reset: assert property (@(posedge core_clk)
    sys_rst |=> (power_state == PWR_ON && !power_strobe))
    else $error("power state survived reset");
  a_store_only: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    scaler_wr_en |-> ($stable(op_mode) && $stable(power_state) && !nv_mode_wr))
    else $error("store request touched local settings");
  a_store_count: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    (scaler_wr_en && scaler_wr_addr[5:0] == CFG_LAST) |-> (tx_valid && tx_byte == ATT_ACK)
    ##1 !scaler_wr_en)
    else $error("store packet length wrong");
  a_mode_restore: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    nv_pend |=> (op_mode == $past(nv_mode_in)))
    else $error("stored operation mode not restored");
  a_recall_ack: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    factory_recall |-> (tx_valid && tx_byte == ATT_ACK && rep_len == LEN_ONE))
    else $error("recall not acknowledged");
  a_nak_reply: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
    (st == SPC_EXEC && !good) |=> (tx_valid && tx_byte == ATT_NAK && rep_len == LEN_QUERY))
    else $error("unserved request not refused");
endmodule
`default_nettype wire
